// ==== rtl/idlcg_defines.svh ====
// register offsets, field positions and reset values of the idle clock gate
// assumes a 32-bit wishbone bus with byte addresses in wb_adr_i
`ifndef IDLCG_DEFINES_SVH
`define IDLCG_DEFINES_SVH

`define IDLCG_ADR_W 8
`define IDLCG_ADR_MODE 8'h00
`define IDLCG_ADR_CTRL 8'h04
`define IDLCG_ADR_CLKSEL 8'h08
`define IDLCG_ADR_EXTMASK 8'h0C
`define IDLCG_ADR_INTMASK 8'h10
`define IDLCG_ADR_PORTOUT 8'h14
`define IDLCG_ADR_PORTDIR 8'h18
`define IDLCG_ADR_STATUS 8'h1C

`define IDLCG_BIT_STOPSEL 0
`define IDLCG_BIT_TRIGGER 1

`define IDLCG_SEL_BT0_EXT 0
`define IDLCG_SEL_BT1_EXT 1
`define IDLCG_SEL_AUX1_SUB 2
`define IDLCG_SEL_WDT2_SUB 3
`define IDLCG_SEL_WATCH_MAIN 4
`define IDLCG_SEL_CSI_LO 5
`define IDLCG_SEL_ASYNC_SERIAL_CHANNEL_ZERO_BAUD 8
`define IDLCG_SEL_SUB_USED 9
`define IDLCG_CLKSEL_W 10

`define IDLCG_EXT_IRQ_W 7
`define IDLCG_INT_IRQ_W 10
`define IDLCG_IRQ_KEY 9

`define IDLCG_RST_MODE 1'h0
`define IDLCG_RST_CLKSEL 10'h000
`define IDLCG_RST_EXTMASK 7'h7F
`define IDLCG_RST_INTMASK 10'h3FF

`endif

// ==== rtl/idlcg_pkg.sv ====
// types shared by the idle clock gate and its testbench
// assumes idlcg_defines.svh is on the include path
package idlcg_pkg;

    typedef enum logic [1:0] {
        IDLCG_RUN = 2'h1,
        IDLCG_IDLE = 2'h2
    } idlcg_state_e;

    // one enable per gated clock domain
    typedef struct packed {
        logic main_osc;
        logic sub_osc;
        logic cpu;
        logic patch;
        logic intc;
        logic tmr16;
        logic byte_tmr0;
        logic byte_tmr1;
        logic aux_tmr0;
        logic aux_tmr1;
        logic watch;
        logic wdt1;
        logic wdt2;
        logic [2:0] csi;
        logic csia;
        logic twowire;
        logic async_serial_channel_zero;
        logic uart_rest;
        logic adc;
        logic dac;
        logic rto;
        logic key;
    } idlcg_gate_s;

    // cause of the last idle release
    typedef struct packed {
        logic by_int;
        logic by_ext;
        logic by_nmi;
    } idlcg_cause_s;

endpackage

// ==== rtl/idlcg_sync.sv ====
// three-stage synchroniser with agreement filter for asynchronous levels
// assumes inputs may change at any time relative to clk_i
`timescale 1ns/10ps
`default_nettype none

module idlcg_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // levels
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
    logic [W-1:0] next_q;

    // a level counts only once stages two and three agree
    genvar g;
    for (g = 0; g < W; g++) begin : g_bit
        always_comb begin
            next_q[g] = (s2[g] == s3[g]) ? s3[g] : q[g];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            q <= '0;
        end else begin
            s1 <= d_i;
            s2 <= s1;
            s3 <= s2;
            q <= next_q;
        end
    end

    assign q_o = q;
endmodule

`default_nettype wire

// ==== rtl/idlcg_top.sv ====
// idle mode clock gate: wishbone registers, idle entry and release,
// per-peripheral clock enables and port/data retention
// assumes wake and reset pins are asynchronous; clocks gated downstream
// How it works
// R1: stop-select clear plus trigger enters idle
// R2: oscillator runs, cpu and main-clock users stop
// R3: nmi, unmasked interrupt or reset pin wakes
// R4: reset pin wake equals ordinary reset
// R5: byte timers run only on external pin
// R6: aux one, watchdog two need subclock selected
// R7: watch timer: subclock, else main output select
// R8: serial channels run only on external clock
// R9: async channel zero only on baud pin
// R10: port levels and directions frozen in idle
// R11: registers and ram preserved during idle
// R12: remaining blocks gated, key interrupt kept
//
// Implementation choices: the register addresses and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
`include "idlcg_defines.svh"

module idlcg_top
    import idlcg_pkg::*;
#(
    parameter int PORT_W = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`IDLCG_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // wake and reset pins
    input wire logic rst_pin_n_i,
    input wire logic nmi_i,
    input wire logic [`IDLCG_EXT_IRQ_W-1:0] ext_irq_i,
    input wire logic [`IDLCG_INT_IRQ_W-1:0] int_irq_i,
    // gating and retention
    output idlcg_gate_s gate_o,
    output logic idle_o,
    output logic sys_reset_o,
    output logic data_hold_o,
    output logic [PORT_W-1:0] port_out_o,
    output logic [PORT_W-1:0] port_dir_o
);
    localparam int EW = `IDLCG_EXT_IRQ_W;
    localparam int IW = `IDLCG_INT_IRQ_W;
    localparam int CW = `IDLCG_CLKSEL_W;
    localparam int SW = 2 + EW + IW;

    logic [SW-1:0] sync_q;
    logic pin_rst;
    logic nmi_s;
    logic [EW-1:0] ext_s;
    logic [IW-1:0] int_s;

    idlcg_sync #(.W(SW)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({~rst_pin_n_i, nmi_i, ext_irq_i, int_irq_i}),
        .q_o(sync_q)
    );
    assign {pin_rst, nmi_s, ext_s, int_s} = sync_q;

    idlcg_state_e state, next_state;
    logic stop_sel, next_stop_sel;
    logic [CW-1:0] clksel, next_clksel;
    logic [EW-1:0] ext_mask, next_ext_mask;
    logic [IW-1:0] int_mask, next_int_mask;
    logic [PORT_W-1:0] port_out, next_port_out;
    logic [PORT_W-1:0] port_dir, next_port_dir;
    idlcg_cause_s cause, next_cause;
    logic ack, next_ack;
    logic [31:0] dat, next_dat;
    idlcg_gate_s gate, next_gate;
    logic idle_q, sys_reset, data_hold;

    logic wr;
    logic [31:0] wmask;
    logic [31:0] wval;
    logic [IW-1:0] int_live;
    logic wake_nmi, wake_ext, wake_int;

    always_comb begin
        wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                 {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
        wval = wb_dat_i & wmask;
        // writes land on the ack edge; refused while the cpu is stopped
        wr = wb_cyc_i && wb_stb_i && ack && wb_we_i
             && state == IDLCG_RUN; // [R11]
    end

    // internal requests count only from peripherals still clocked
    always_comb begin
        int_live = {gate.key, gate.async_serial_channel_zero, gate.csi, gate.watch,
                    gate.wdt2, gate.aux_tmr1, gate.byte_tmr1,
                    gate.byte_tmr0};
        wake_nmi = nmi_s; // [R3]
        wake_ext = |(ext_s & ~ext_mask); // [R3]
        wake_int = |(int_s & ~int_mask & int_live); // [R3]
    end

    // state and registers
    always_comb begin
        next_state = state;
        next_stop_sel = stop_sel;
        next_clksel = clksel;
        next_ext_mask = ext_mask;
        next_int_mask = int_mask;
        next_port_out = port_out;
        next_port_dir = port_dir;
        next_cause = cause;
        if (wr) begin
            unique case (wb_adr_i)
                `IDLCG_ADR_MODE: begin
                    if (wb_sel_i[0]) begin
                        next_stop_sel = wval[`IDLCG_BIT_STOPSEL];
                    end
                end
                `IDLCG_ADR_CTRL: begin
                    // stop mode is not handled here; trigger ignored
                    if (wval[`IDLCG_BIT_TRIGGER] && !stop_sel) begin
                        next_state = IDLCG_IDLE; // [R1]
                    end
                end
                `IDLCG_ADR_CLKSEL: begin
                    next_clksel = (clksel & ~wmask[CW-1:0])
                                  | wval[CW-1:0];
                end
                `IDLCG_ADR_EXTMASK: begin
                    next_ext_mask = (ext_mask & ~wmask[EW-1:0])
                                    | wval[EW-1:0];
                end
                `IDLCG_ADR_INTMASK: begin
                    next_int_mask = (int_mask & ~wmask[IW-1:0])
                                    | wval[IW-1:0];
                end
                `IDLCG_ADR_PORTOUT: begin
                    next_port_out = (port_out & ~wmask[PORT_W-1:0])
                                    | wval[PORT_W-1:0];
                end
                `IDLCG_ADR_PORTDIR: begin
                    next_port_dir = (port_dir & ~wmask[PORT_W-1:0])
                                    | wval[PORT_W-1:0];
                end
                default: begin
                end
            endcase
        end
        // release goes straight to run: oscillator never stopped
        if (state == IDLCG_IDLE && (wake_nmi || wake_ext || wake_int)) begin
            next_state = IDLCG_RUN; // [R3]
            next_cause = '{by_int: wake_int, by_ext: wake_ext,
                           by_nmi: wake_nmi};
        end
    end

    // bus answer: one cycle after the request, unmapped reads zero
    always_comb begin
        next_ack = wb_cyc_i && wb_stb_i && !ack;
        next_dat = '0;
        if (next_ack && !wb_we_i) begin
            unique case (wb_adr_i)
                `IDLCG_ADR_MODE: next_dat[`IDLCG_BIT_STOPSEL] = stop_sel;
                `IDLCG_ADR_CTRL:
                    next_dat[`IDLCG_BIT_TRIGGER] = (state == IDLCG_IDLE);
                `IDLCG_ADR_CLKSEL: next_dat[CW-1:0] = clksel;
                `IDLCG_ADR_EXTMASK: next_dat[EW-1:0] = ext_mask;
                `IDLCG_ADR_INTMASK: next_dat[IW-1:0] = int_mask;
                `IDLCG_ADR_PORTOUT: next_dat[PORT_W-1:0] = port_out;
                `IDLCG_ADR_PORTDIR: next_dat[PORT_W-1:0] = port_dir;
                `IDLCG_ADR_STATUS: next_dat[3:0] = {cause,
                                                 state == IDLCG_IDLE};
                default: next_dat = '0;
            endcase
        end
    end

    // enables follow next_state so gate_o lines up with state
    always_comb begin
        logic run;
        logic sub;
        run = (next_state == IDLCG_RUN);
        sub = next_clksel[`IDLCG_SEL_SUB_USED];
        next_gate.main_osc = 1'b1; // [R2]
        next_gate.sub_osc = sub;
        next_gate.cpu = run; // [R2]
        next_gate.patch = run; // [R12]
        next_gate.intc = run; // [R12]
        next_gate.tmr16 = run; // [R12]
        next_gate.aux_tmr0 = run; // [R12]
        next_gate.wdt1 = run; // [R12]
        next_gate.csia = run; // [R12]
        next_gate.twowire = run; // [R12]
        next_gate.adc = run; // [R12]
        next_gate.dac = run; // [R12]
        next_gate.rto = run; // [R12]
        next_gate.key = 1'b1; // [R12]
        next_gate.byte_tmr0 = run || next_clksel[`IDLCG_SEL_BT0_EXT]; // [R5]
        next_gate.byte_tmr1 = run || next_clksel[`IDLCG_SEL_BT1_EXT]; // [R5]
        next_gate.aux_tmr1 = run
            || (sub && next_clksel[`IDLCG_SEL_AUX1_SUB]); // [R6]
        next_gate.wdt2 = run
            || (sub && next_clksel[`IDLCG_SEL_WDT2_SUB]); // [R6]
        next_gate.watch = run || sub
            || next_clksel[`IDLCG_SEL_WATCH_MAIN]; // [R7]
        next_gate.csi = {3{run}}
            | next_clksel[`IDLCG_SEL_CSI_LO +: 3]; // [R8]
        next_gate.async_serial_channel_zero = run || next_clksel[`IDLCG_SEL_ASYNC_SERIAL_CHANNEL_ZERO_BAUD]; // [R9]
        next_gate.uart_rest = run; // [R9]
    end

    // the reset pin runs the same reset as rst_i on state and registers, but not on ack, dat or sys_reset
    always_ff @(posedge clk_i) begin
        if (rst_i || pin_rst) begin // [R4]
            state <= IDLCG_RUN;
            stop_sel <= `IDLCG_RST_MODE;
            clksel <= `IDLCG_RST_CLKSEL;
            ext_mask <= `IDLCG_RST_EXTMASK;
            int_mask <= `IDLCG_RST_INTMASK;
            port_out <= '0;
            port_dir <= '0;
            cause <= '0;
            gate <= '{main_osc: 1'b1, cpu: 1'b1, patch: 1'b1, intc: 1'b1,
                      tmr16: 1'b1, byte_tmr0: 1'b1, byte_tmr1: 1'b1,
                      aux_tmr0: 1'b1, aux_tmr1: 1'b1, watch: 1'b1,
                      wdt1: 1'b1, wdt2: 1'b1, csi: 3'h7, csia: 1'b1,
                      twowire: 1'b1, async_serial_channel_zero: 1'b1, uart_rest: 1'b1,
                      adc: 1'b1, dac: 1'b1, rto: 1'b1, key: 1'b1,
                      sub_osc: 1'b0};
            idle_q <= 1'b0;
            data_hold <= 1'b0;
        end else begin
            state <= next_state;
            stop_sel <= next_stop_sel;
            clksel <= next_clksel;
            ext_mask <= next_ext_mask;
            int_mask <= next_int_mask;
            port_out <= next_port_out; // [R10]
            port_dir <= next_port_dir; // [R10]
            cause <= next_cause;
            gate <= next_gate;
            idle_q <= (next_state == IDLCG_IDLE);
            data_hold <= (next_state == IDLCG_IDLE); // [R11]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack <= 1'b0;
            dat <= '0;
            sys_reset <= 1'b0;
        end else begin
            ack <= next_ack;
            dat <= next_dat;
            sys_reset <= pin_rst; // [R4]
        end
    end

    assign wb_ack_o = ack;
    assign wb_dat_o = dat;
    assign gate_o = gate;
    assign idle_o = idle_q;
    assign sys_reset_o = sys_reset;
    assign data_hold_o = data_hold;
    assign port_out_o = port_out;
    assign port_dir_o = port_dir;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_trigger;
        wr && wb_adr_i == `IDLCG_ADR_CTRL
        && wb_dat_i[`IDLCG_BIT_TRIGGER] && wb_sel_i[0] && !pin_rst;
    endsequence
    sequence s_wake;
        state == IDLCG_IDLE && !pin_rst
        && (wake_nmi || wake_ext || wake_int);
    endsequence

    a_idle_entry: assert property (s_trigger and !stop_sel |=> idle_o) // [R1]
        else $error("trigger with stop select clear did not idle");
    a_stop_ignored: assert property (s_trigger and stop_sel // [R1]
        |=> !idle_o)
        else $error("trigger with stop select set entered idle");
    a_cpu_gated: assert property (idle_o // [R2]
        |-> !gate_o.cpu && gate_o.main_osc)
        else $error("cpu clock running or oscillator off in idle");
    a_wake_release: assert property (s_wake |=> !idle_o && gate_o.cpu) // [R3]
        else $error("wake request did not release idle");
    a_pin_reset: assert property (pin_rst |=> !idle_o && sys_reset_o // [R4]
        && !stop_sel && port_dir_o == '0)
        else $error("reset pin did not act as ordinary reset");
    a_byte_timers: assert property (idle_o |-> gate_o.byte_tmr0 // [R5]
        == clksel[`IDLCG_SEL_BT0_EXT] && gate_o.byte_tmr1
        == clksel[`IDLCG_SEL_BT1_EXT])
        else $error("byte timer gating wrong in idle");
    a_sub_timers: assert property (idle_o |-> gate_o.aux_tmr1 // [R6]
        == (clksel[`IDLCG_SEL_SUB_USED] && clksel[`IDLCG_SEL_AUX1_SUB]))
        else $error("aux timer one gating wrong in idle");
    a_watch_timer: assert property (idle_o // [R7]
        && !clksel[`IDLCG_SEL_SUB_USED]
        |-> gate_o.watch == clksel[`IDLCG_SEL_WATCH_MAIN])
        else $error("watch timer gating wrong in idle");
    a_serial_gate: assert property (idle_o |-> gate_o.csi // [R8]
        == clksel[`IDLCG_SEL_CSI_LO +: 3] && !gate_o.uart_rest)
        else $error("serial channel gating wrong in idle");
    a_uart_gate: assert property (idle_o |-> gate_o.async_serial_channel_zero // [R9]
        == clksel[`IDLCG_SEL_ASYNC_SERIAL_CHANNEL_ZERO_BAUD])
        else $error("async channel zero gating wrong in idle");
    a_port_hold: assert property (idle_o && !pin_rst |=> // [R10]
        $stable(port_out_o) && $stable(port_dir_o))
        else $error("port changed during idle");
    a_data_hold: assert property (idle_o ##1 idle_o |-> // [R11]
        data_hold_o && $stable(clksel) && $stable(int_mask))
        else $error("internal state changed during idle");
    a_rest_gated: assert property (idle_o |-> gate_o.key // [R12]
        && !gate_o.intc && !gate_o.adc && !gate_o.twowire && !gate_o.rto)
        else $error("idle gating of other blocks wrong");
endmodule

`default_nettype wire

// ==== test/tb_idle_mode_clock_gating.sv ====
// self-checking bench for the idle clock gate: entry, gating, wake, retention
// assumes the design's wishbone slave acks one cycle after taking a request
`timescale 1ns/10ps
`default_nettype none
`include "idlcg_defines.svh"

`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end

module tb_idle_mode_clock_gating
    import idlcg_pkg::*;
;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic rst_pin_n_i, nmi_i, idle_o, sys_reset_o, data_hold_o;
    logic [6:0] ext_irq_i;
    logic [9:0] int_irq_i;
    logic [7:0] port_out_o, port_dir_o;
    idlcg_gate_s gate_o;
    int mismatches = 0;
    int compares = 0;
    logic [31:0] seed = 32'hFEAA;

    idlcg_top #(.PORT_W(8)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .rst_pin_n_i(rst_pin_n_i), .nmi_i(nmi_i),
        .ext_irq_i(ext_irq_i), .int_irq_i(int_irq_i), .gate_o(gate_o),
        .idle_o(idle_o), .sys_reset_o(sys_reset_o),
        .data_hold_o(data_hold_o), .port_out_o(port_out_o),
        .port_dir_o(port_dir_o)
    );

    always #50 clk_i = ~clk_i;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // gate pattern expected while idle for a given clock selection
    function automatic idlcg_gate_s exp_gate(input logic [9:0] s);
        idlcg_gate_s g;
        g = '0;
        g.main_osc = 1'b1;
        g.sub_osc = s[`IDLCG_SEL_SUB_USED];
        g.byte_tmr0 = s[`IDLCG_SEL_BT0_EXT];
        g.byte_tmr1 = s[`IDLCG_SEL_BT1_EXT];
        g.aux_tmr1 = s[`IDLCG_SEL_SUB_USED] & s[`IDLCG_SEL_AUX1_SUB];
        g.wdt2 = s[`IDLCG_SEL_SUB_USED] & s[`IDLCG_SEL_WDT2_SUB];
        g.watch = s[`IDLCG_SEL_SUB_USED] | s[`IDLCG_SEL_WATCH_MAIN];
        g.csi = s[7:5];
        g.async_serial_channel_zero = s[`IDLCG_SEL_ASYNC_SERIAL_CHANNEL_ZERO_BAUD];
        g.key = 1'b1;
        return g;
    endfunction

    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic wb(input logic we, input logic [7:0] adr,
                      input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        `CHK("wb_ack", 1'b1, wb_ack_o)
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    initial begin
        #(100 * 20000);
        mismatches++;
        end_sim();
    end

    // reads after reset: address, expected value
    logic [7:0] ra [6] = '{`IDLCG_ADR_MODE, `IDLCG_ADR_CLKSEL,
        `IDLCG_ADR_EXTMASK, `IDLCG_ADR_INTMASK, `IDLCG_ADR_PORTOUT, 8'h20};
    logic [31:0] rv [6] = '{32'h0, 32'h0, 32'h7F, 32'h3FF, 32'h0, 32'h0};
    logic [3:0] cause [4] = '{4'h2, 4'h4, 4'h8, 4'h0};

    initial begin
        logic [31:0] rd, p, q;
        logic [9:0] sel;
        idlcg_gate_s g;
        int n;
        clk_i = 1'b0;
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h0;
        rst_pin_n_i = 1'b1;
        nmi_i = 1'b0;
        ext_irq_i = 7'h00;
        int_irq_i = 10'h000;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        g = '1;
        g.sub_osc = 1'b0;
        `CHK("gate_rst", g, gate_o)
        for (int k = 0; k < 6; k++) begin
            wb(1'b0, ra[k], 32'h0, rd);
            `CHK("reg_rst", rv[k], rd)
        end
        // stop select set: trigger must not enter idle
        wb(1'b1, `IDLCG_ADR_MODE, 32'h1, rd);
        wb(1'b1, `IDLCG_ADR_CTRL, 32'h2, rd);
        repeat (2) @(posedge clk_i);
        #1;
        `CHK("idle_refused", 1'b0, idle_o)
        for (int i = 0; i < 8; i++) begin
            p = rnd();
            sel = p[9:0];
            // odd passes clock csi0 externally; its request is masked then
            sel[5] = i[0];
            p = rnd();
            q = rnd();
            wb(1'b1, `IDLCG_ADR_MODE, 32'h0, rd);
            wb(1'b1, `IDLCG_ADR_CLKSEL, {22'h0, sel}, rd);
            wb(1'b1, `IDLCG_ADR_EXTMASK, 32'h7E, rd);
            wb(1'b1, `IDLCG_ADR_INTMASK,
               {22'h0, 10'h1DF | {4'h0, sel[5], 5'h0}}, rd);
            wb(1'b1, `IDLCG_ADR_PORTOUT, p, rd);
            wb(1'b1, `IDLCG_ADR_PORTDIR, q, rd);
            wb(1'b1, `IDLCG_ADR_CTRL, 32'h2, rd);
            @(posedge clk_i);
            #1;
            `CHK("idle_entry", 1'b1, idle_o)
            g = exp_gate(sel);
            `CHK("gate_idle", g, gate_o)
            `CHK("data_hold", 1'b1, data_hold_o)
            // writes in idle are acked but must leave state untouched
            wb(1'b1, `IDLCG_ADR_PORTOUT, ~p, rd);
            wb(1'b1, `IDLCG_ADR_CLKSEL, 32'h0, rd);
            wb(1'b0, `IDLCG_ADR_CLKSEL, 32'h0, rd);
            `CHK("clksel_kept", sel, rd[9:0])
            wb(1'b0, `IDLCG_ADR_CTRL, 32'h0, rd);
            `CHK("ctrl_idle", 1'b1, rd[1])
            `CHK("port_out", p[7:0], port_out_o)
            `CHK("port_dir", q[7:0], port_dir_o)
            // masked ext line and a gated or masked source must not wake
            ext_irq_i <= 7'h02;
            int_irq_i <= 10'h020;
            repeat (8) @(posedge clk_i);
            #1;
            `CHK("no_wake", 1'b1, idle_o)
            @(posedge clk_i);
            case (i % 4)
                0: nmi_i <= 1'b1;
                1: ext_irq_i <= 7'h03;
                2: int_irq_i <= 10'h220;
                default: rst_pin_n_i <= 1'b0;
            endcase
            repeat (2) @(posedge clk_i);
            #1;
            `CHK("wake_early", 1'b1, idle_o)
            n = 0;
            while (idle_o === 1'b1 && n < 10) begin
                @(posedge clk_i);
                #1;
                n++;
            end
            `CHK("wake", 1'b1, n < 4)
            if (i % 4 == 3) begin
                repeat (2) @(posedge clk_i);
                #1;
                `CHK("sys_reset", 1'b1, sys_reset_o)
            end
            @(posedge clk_i);
            nmi_i <= 1'b0;
            ext_irq_i <= 7'h00;
            int_irq_i <= 10'h000;
            rst_pin_n_i <= 1'b1;
            repeat (8) @(posedge clk_i);
            #1;
            g = gate_o;
            g.sub_osc = 1'b1;
            `CHK("gate_run", '1, g)
            `CHK("hold_off", 1'b0, data_hold_o)
            `CHK("sys_reset_off", 1'b0, sys_reset_o)
            wb(1'b0, `IDLCG_ADR_STATUS, 32'h0, rd);
            `CHK("status", cause[i % 4], rd[3:0])
            if (i % 4 == 3) begin
                wb(1'b0, `IDLCG_ADR_PORTOUT, 32'h0, rd);
                `CHK("port_rst", 32'h0, rd)
                `CHK("port_pin_rst", 8'h00, port_out_o)
            end
        end
        end_sim();
    end
endmodule
`default_nettype wire
